// ==== pkg/i2cee_pkg.sv ====
// Operation
// [R01] Transmitter releases data after eight bits; receiver pulls it low in the ninth clock.
// [R02] Data is sampled on serial clock rise; master changes it only while clock is low.
// [R03] Select byte, MSB first: 4-bit type id, zero bit, two chip selects, direction.
// [R04] Respond only when select bits equal the two chip select pins.
// [R05] Direction 1 reads, 0 writes; match acknowledges, mismatch releases and idles.
// [R06] Address is two bytes, high first; top address bit ignored, fifteen bits used.
// [R07] Write select acknowledged, then both address bytes acknowledged before data.
// [R08] Write inhibit high from START to address end: no change, data not acknowledged.
// [R09] Byte write: one data byte then STOP; acknowledged only when not inhibited.
// [R10] Page write carries one to 64 bytes, all within one row.
// [R11] Each received data byte increments only the low six address bits, wrapping in row; the code skips the increment for inhibited bytes.
// [R12] Write cycle starts only on STOP right after a data acknowledge.
// [R13] During the write cycle all input and requests are ignored.
// [R14] Master polls with START and select until acknowledged.
// [R15] Reads work whatever the write inhibit level.
// [R16] Random read: write select, address, repeated START, read select, one byte, no ack.
// [R17] Master repeats the same upper seven select bits in a random read.
// [R18] Current read acknowledges, sends byte at counter, then increments counter.
// [R19] START is data fall with clock high, STOP data rise; START watched unless busy.
// [R20] Sequential read: each master ack sends next byte; counter wraps to zero.
// [R21] No master ack after a read byte ends the transfer and idles.
// [R22] Write cycle length is a parameter; device stays busy until it elapses.
package i2cee_pkg;

  // ==========================================================
  // Timing
  localparam int CLK_MHZ = 10;
  localparam int WRITE_CYCLE_TIME_US = 5000;

  // ==========================================================
  // Geometry
  localparam int ADDR_W = 15;
  localparam int PAGE_W = 6;
  localparam int PAGE_BYTES = 64;
  localparam int HI_USED_W = ADDR_W - 8;

  // ==========================================================
  // Bit slot counts
  localparam logic [3:0] BIT_FIRST = 4'h0;
  localparam logic [3:0] BIT_STEP = 4'h1;
  localparam logic [3:0] BIT_LAST = 4'h7;
  localparam logic [3:0] BIT_ACK = 4'h8;
  localparam logic [3:0] BIT_TENTH = 4'h9;

  // ==========================================================
  // Select byte fields
  localparam int SEL_TYPE_MSB = 7;
  localparam int SEL_TYPE_LSB = 4;
  localparam int SEL_FIX_BIT = 3;
  localparam int SEL_CS_HI_BIT = 2;
  localparam int SEL_CS_LO_BIT = 1;
  localparam int SEL_RW_BIT = 0;
  localparam logic SEL_FIX_VAL = 1'b0;
  localparam logic RW_READ = 1'b1;

  // ==========================================================
  // Pin levels
  localparam logic SDA_DRIVE_LEVEL = 1'b0;
  localparam logic [2:0] PINS_RESET = 3'h0;

  // ==========================================================
  // Types
  typedef enum logic [1:0] {ST_IDLE, ST_RX, ST_TX} i2cee_state_t;
  typedef enum logic [1:0] {K_DEV, K_AHI, K_ALO, K_DATA} i2cee_kind_t;

  typedef struct packed {
    logic scl;
    logic sda;
  } i2cee_line_t;

  localparam i2cee_line_t LINE_IDLE = 2'h3;

endpackage

// ==== hw/i2cee_slave.sv ====
`timescale 1ns/1ns
`default_nettype none
module i2cee_slave import i2cee_pkg::*; #(
  // Arbitrary type id value
  parameter logic [3:0] DEV_TYPE_ID = 4'hC,
  parameter int WRITE_CYCLE_US = WRITE_CYCLE_TIME_US,
  parameter int MEM_DEPTH = 32768
) (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic scl_pin,
  input wire logic sda_pin_in,
  output logic sda_pin_out,
  output logic sda_pin_oe,
  input wire logic write_inhibit_pin,
  input wire logic chip_select_pin_low,
  input wire logic chip_select_pin_high,
  output logic write_busy
);

  // ==========================================================
  // Derived counts
  localparam int WC_RAW = WRITE_CYCLE_US * CLK_MHZ;
  localparam int WC_CYCLES = (WC_RAW < 1) ? 1 : WC_RAW;
  localparam int CNT_W = $clog2(WC_CYCLES + 1);
  localparam int ROW_W = ADDR_W - PAGE_W;

  // ==========================================================
  // Declarations
  i2cee_line_t line_s1_reg;
  i2cee_line_t line_s2_reg;
  i2cee_line_t line_prev_reg;
  logic [2:0] pins_s1_reg;
  logic [2:0] pins_s2_reg;
  logic wc_lvl;
  logic [1:0] cs_lvl;

  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  logic [7:0] rx_byte;
  logic sel_match;
  logic byte_done;
  logic data_take;
  logic commit;
  logic busy;

  i2cee_state_t state_reg;
  i2cee_kind_t kind_reg;
  logic [3:0] bitcnt_reg;
  logic [7:0] shreg_reg;
  logic ack_reg;
  logic oe_reg;
  logic rd_reg;
  logic arm_reg;
  logic inhibit_reg;
  logic [ADDR_W-1:0] addr_reg;
  logic [HI_USED_W-1:0] addr_hi_reg;
  logic [CNT_W-1:0] busy_cnt_reg;

  logic [7:0] page_reg [PAGE_BYTES];
  logic [PAGE_BYTES-1:0] valid_reg;
  logic [7:0] mem_reg [MEM_DEPTH];
  logic [7:0] mem_rd;

  // ==========================================================
  // Pin synchronisers
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      line_s1_reg <= LINE_IDLE;
      line_s2_reg <= LINE_IDLE;
      line_prev_reg <= LINE_IDLE;
    end else begin
      line_s1_reg <= '{scl: scl_pin, sda: sda_pin_in};
      line_s2_reg <= line_s1_reg;
      line_prev_reg <= line_s2_reg;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      pins_s1_reg <= PINS_RESET;
      pins_s2_reg <= PINS_RESET;
    end else begin
      pins_s1_reg <= {write_inhibit_pin, chip_select_pin_high, chip_select_pin_low};
      pins_s2_reg <= pins_s1_reg;
    end
  end

  assign wc_lvl = pins_s2_reg[2];
  assign cs_lvl = pins_s2_reg[1:0];

  // ==========================================================
  // Line events
  assign scl_rise = line_s2_reg.scl & ~line_prev_reg.scl; // [R02]
  assign scl_fall = ~line_s2_reg.scl & line_prev_reg.scl;
  assign start_det = line_s2_reg.scl & line_prev_reg.scl & line_prev_reg.sda & ~line_s2_reg.sda; // [R19]
  assign stop_det = line_s2_reg.scl & line_prev_reg.scl & ~line_prev_reg.sda & line_s2_reg.sda; // [R19]

  // ==========================================================
  // Byte decode
  assign rx_byte = {shreg_reg[6:0], line_s2_reg.sda}; // [R03]
  assign sel_match = (rx_byte[SEL_TYPE_MSB:SEL_TYPE_LSB] == DEV_TYPE_ID)
    && (rx_byte[SEL_FIX_BIT] == SEL_FIX_VAL)
    && (rx_byte[SEL_CS_HI_BIT] == cs_lvl[1])
    && (rx_byte[SEL_CS_LO_BIT] == cs_lvl[0]); // [R04]
  assign byte_done = (state_reg == ST_RX) && scl_rise && (bitcnt_reg == BIT_LAST);
  assign data_take = byte_done && (kind_reg == K_DATA) && !inhibit_reg && !busy; // [R08] [R09]
  assign commit = stop_det && arm_reg && !busy; // [R12]
  assign busy = (busy_cnt_reg != '0);
  assign mem_rd = mem_reg[addr_reg];

  // ==========================================================
  // Write cycle timer
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      busy_cnt_reg <= '0;
    end else if (commit) begin
      busy_cnt_reg <= CNT_W'(WC_CYCLES); // [R22]
    end else if (busy) begin
      busy_cnt_reg <= CNT_W'(busy_cnt_reg - 1'b1);
    end
  end

  // ==========================================================
  // Page latch
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      valid_reg <= '0;
    end else if (start_det && !busy) begin
      valid_reg <= '0;
    end else if (data_take) begin
      valid_reg[addr_reg[PAGE_W-1:0]] <= 1'b1; // [R10]
    end
  end

  always_ff @(posedge sys_clk) begin
    if (data_take) begin
      page_reg[addr_reg[PAGE_W-1:0]] <= rx_byte; // [R11]
    end
  end

  // ==========================================================
  // Array commit
  always_ff @(posedge sys_clk) begin
    if (commit) begin
      for (int i = 0; i < PAGE_BYTES; i++) begin
        if (valid_reg[i]) begin
          mem_reg[{addr_reg[ADDR_W-1:PAGE_W], PAGE_W'(i)}] <= page_reg[i]; // [R10]
        end
      end
    end
  end

  // ==========================================================
  // Protocol engine
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= ST_IDLE;
      kind_reg <= K_DEV;
      bitcnt_reg <= BIT_FIRST;
      shreg_reg <= '0;
      ack_reg <= 1'b0;
      oe_reg <= 1'b0;
      rd_reg <= 1'b0;
      arm_reg <= 1'b0;
      inhibit_reg <= 1'b0;
      addr_reg <= '0;
      addr_hi_reg <= '0;
    end else if (busy) begin
      // Deaf while writing
      state_reg <= ST_IDLE; // [R13]
      oe_reg <= 1'b0; // [R13]
      arm_reg <= 1'b0;
    end else if (start_det) begin
      state_reg <= ST_RX; // [R19]
      kind_reg <= K_DEV;
      bitcnt_reg <= BIT_FIRST;
      oe_reg <= 1'b0;
      arm_reg <= 1'b0;
      inhibit_reg <= wc_lvl; // [R08]
    end else if (stop_det) begin
      state_reg <= ST_IDLE;
      oe_reg <= 1'b0;
      arm_reg <= 1'b0;
    end else begin
      if (state_reg == ST_RX && kind_reg != K_DATA) begin
        inhibit_reg <= inhibit_reg | wc_lvl; // [R08]
      end
      if (scl_fall) begin
        // Clock low after the tenth slot disarms
        arm_reg <= 1'b0; // [R12]
      end
      unique case (state_reg)
        ST_IDLE: begin
          oe_reg <= 1'b0;
        end
        ST_RX: begin
          if (scl_rise) begin
            if (bitcnt_reg < BIT_ACK) begin
              shreg_reg <= rx_byte; // [R02]
              bitcnt_reg <= 4'(bitcnt_reg + BIT_STEP);
            end else begin
              bitcnt_reg <= BIT_TENTH;
            end
            if (bitcnt_reg == BIT_LAST) begin
              unique case (kind_reg)
                K_DEV: begin
                  ack_reg <= sel_match; // [R05]
                  rd_reg <= (rx_byte[SEL_RW_BIT] == RW_READ); // [R05]
                  if (!sel_match) begin
                    state_reg <= ST_IDLE; // [R05]
                  end
                end
                K_AHI: begin
                  addr_hi_reg <= rx_byte[HI_USED_W-1:0]; // [R06]
                  ack_reg <= 1'b1; // [R07]
                end
                K_ALO: begin
                  addr_reg <= {addr_hi_reg, rx_byte}; // [R06]
                  ack_reg <= 1'b1; // [R07]
                end
                K_DATA: begin
                  ack_reg <= !inhibit_reg; // [R08] [R09]
                  if (!inhibit_reg) begin
                    addr_reg[PAGE_W-1:0] <= PAGE_W'(addr_reg[PAGE_W-1:0] + 1'b1); // [R11]
                  end
                end
              endcase
            end
          end else if (scl_fall) begin
            if (bitcnt_reg == BIT_ACK) begin
              oe_reg <= ack_reg; // [R01]
            end else if (bitcnt_reg == BIT_TENTH) begin
              oe_reg <= 1'b0; // [R01]
              bitcnt_reg <= BIT_FIRST;
              if (kind_reg == K_DEV && rd_reg) begin
                // First read byte, current or random
                state_reg <= ST_TX; // [R15] [R16]
                shreg_reg <= mem_rd; // [R18]
                oe_reg <= ~mem_rd[7]; // [R18]
                addr_reg <= ADDR_W'(addr_reg + 1'b1); // [R18]
              end else begin
                arm_reg <= (kind_reg == K_DATA) && ack_reg; // [R12]
                unique case (kind_reg)
                  K_DEV: kind_reg <= K_AHI; // [R07]
                  K_AHI: kind_reg <= K_ALO; // [R07]
                  K_ALO: kind_reg <= K_DATA;
                  K_DATA: kind_reg <= K_DATA;
                endcase
              end
            end
          end
        end
        ST_TX: begin
          if (scl_rise) begin
            if (bitcnt_reg < BIT_ACK) begin
              shreg_reg <= {shreg_reg[6:0], 1'b0};
              bitcnt_reg <= 4'(bitcnt_reg + BIT_STEP);
            end else if (bitcnt_reg == BIT_ACK) begin
              if (!line_s2_reg.sda) begin
                bitcnt_reg <= BIT_TENTH; // [R20]
              end else begin
                state_reg <= ST_IDLE; // [R21]
              end
            end
          end else if (scl_fall) begin
            if (bitcnt_reg == BIT_ACK) begin
              oe_reg <= 1'b0; // [R01]
            end else if (bitcnt_reg == BIT_TENTH) begin
              bitcnt_reg <= BIT_FIRST;
              shreg_reg <= mem_rd; // [R20]
              oe_reg <= ~mem_rd[7]; // [R20]
              addr_reg <= ADDR_W'(addr_reg + 1'b1); // [R20]
            end else if (bitcnt_reg != BIT_FIRST) begin
              oe_reg <= ~shreg_reg[7]; // [R02]
            end
          end
        end
      endcase
    end
  end

  // ==========================================================
  // Outputs
  assign sda_pin_out = SDA_DRIVE_LEVEL;
  assign sda_pin_oe = oe_reg;
  assign write_busy = busy;

endmodule // i2cee_slave
`default_nettype wire

// ==== testbench/i2cee_slave_assertions.sv ====
`timescale 1ns/1ns
`default_nettype none
module i2cee_slave_checker import i2cee_pkg::*; #(
  parameter int WRITE_CYCLE_US = WRITE_CYCLE_TIME_US
) (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic scl_pin,
  input wire logic sda_pin_in,
  input wire logic sda_pin_out,
  input wire logic sda_pin_oe,
  input wire logic write_inhibit_pin,
  input wire logic chip_select_pin_low,
  input wire logic chip_select_pin_high,
  input wire logic write_busy
);
  // ====
  // Busy run length
  localparam int WC = WRITE_CYCLE_US * CLK_MHZ;
  logic [19:0] bcnt_reg;
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      bcnt_reg <= 20'h00000;
    end else begin
      bcnt_reg <= write_busy ? bcnt_reg + 20'h00001 : 20'h00000;
    end
  end
  // ====
  // Properties
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  property p_out_zero; sda_pin_out == SDA_DRIVE_LEVEL; endproperty
  a_out_zero: assert property (p_out_zero) else $error("drive level not low");
  property p_busy_quiet; write_busy |-> !sda_pin_oe; endproperty
  a_busy_quiet: assert property (p_busy_quiet) else $error("driven while busy");
  property p_busy_len; $fell(write_busy) |-> bcnt_reg == WC; endproperty
  a_busy_len: assert property (p_busy_len) else $error("busy length wrong");
  property p_busy_min; $rose(write_busy) |=> write_busy [*8]; endproperty
  a_busy_min: assert property (p_busy_min) else $error("busy too short");
  property p_busy_cause; $rose(write_busy) |-> scl_pin && sda_pin_in; endproperty
  a_busy_cause: assert property (p_busy_cause) else $error("busy without stop");
  property p_oe_low_clk; $changed(sda_pin_oe) |-> !$past(scl_pin, 2); endproperty
  a_oe_low_clk: assert property (p_oe_low_clk) else $error("drive moved with clock high");
  property p_oe_hold; $rose(scl_pin) |-> ##2 $stable(sda_pin_oe) [*2]; endproperty
  a_oe_hold: assert property (p_oe_hold) else $error("drive moved after clock rise");
  property p_start_quiet; $fell(sda_pin_in) && scl_pin && !write_busy |=> !sda_pin_oe [*8]; endproperty
  a_start_quiet: assert property (p_start_quiet) else $error("driven after start");
endmodule // i2cee_slave_checker
bind i2cee_slave i2cee_slave_checker #(.WRITE_CYCLE_US(WRITE_CYCLE_US)) u_chk (.sys_clk(sys_clk),
  .arst_n(arst_n), .scl_pin(scl_pin), .sda_pin_in(sda_pin_in), .sda_pin_out(sda_pin_out),
  .sda_pin_oe(sda_pin_oe), .write_inhibit_pin(write_inhibit_pin), .chip_select_pin_low(chip_select_pin_low),
  .chip_select_pin_high(chip_select_pin_high), .write_busy(write_busy));
`default_nettype wire

// ==== testbench/i2cee_master_model.sv ====
`timescale 1ns/1ns
`default_nettype none
module i2cee_master_model (
  input wire logic clk,
  input wire logic sda,
  output logic scl,
  output logic sda_low,
  output logic res_tgl,
  output logic [7:0] res_dat
);
  // ====
  // Bus phases
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
    res_tgl = 1'b0;
    res_dat = 8'h00;
  end
  task automatic qt(input int n);
    repeat (2 * n) @(posedge clk);
    #1;
  endtask
  task automatic bit_io(input logic b, output logic r);
    qt(1);
    sda_low = ~b;
    qt(1);
    scl = 1'b1;
    qt(1);
    r = sda;
    qt(1);
    scl = 1'b0;
  endtask
  task automatic start();
    qt(2);
    sda_low = 1'b0;
    qt(1);
    scl = 1'b1;
    qt(1);
    sda_low = 1'b1;
    qt(1);
    scl = 1'b0;
  endtask
  task automatic stop();
    qt(1);
    sda_low = 1'b1;
    qt(1);
    scl = 1'b1;
    qt(1);
    sda_low = 1'b0;
    qt(2);
  endtask
  task automatic wr_byte(input logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, r);
    res_dat = {7'h00, r};
    res_tgl = ~res_tgl;
  endtask
  task automatic rd_byte(input logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      res_dat[i] = r;
    end
    res_tgl = ~res_tgl;
    bit_io(~ack, r);
  endtask
endmodule // i2cee_master_model
`default_nettype wire

// ==== testbench/i2cee_slave_bench.sv ====
`timescale 1ns/1ns
`default_nettype none
module i2cee_slave_bench;
  // ====
  // Harness
  localparam logic [3:0] TID = 4'h5; // Arbitrary type id
  logic sys_clk, arst_n, wi, cs_lo, cs_hi, scl, m_low, oe, dout, busy, tgl;
  logic [7:0] dat;
  logic [1:0] cs;
  logic [7:0] d [6];
  logic [7:0] bad [3];
  logic [7:0] q [$];
  int error_cnt = 0;
  int comparisons = 0;
  int cyc = 0;
  wire logic sda = ~(m_low | oe);
  i2cee_slave #(.DEV_TYPE_ID(TID), .WRITE_CYCLE_US(10)) dut (.sys_clk(sys_clk), .arst_n(arst_n), .scl_pin(scl),
    .sda_pin_in(sda), .sda_pin_out(dout), .sda_pin_oe(oe), .write_inhibit_pin(wi), .chip_select_pin_low(cs_lo),
    .chip_select_pin_high(cs_hi), .write_busy(busy));
  i2cee_master_model m (.clk(sys_clk), .sda(sda), .scl(scl), .sda_low(m_low), .res_tgl(tgl), .res_dat(dat));
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      tally_and_finish();
    end
  end
  always @(tgl) begin
    #1;
    if (q.size() != 0) chk("result", q.pop_front(), dat);
  end
  // ====
  // Tasks
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
    comparisons++;
    if (s !== e) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic tally_and_finish();
    $display("errors %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  function automatic logic [7:0] sel(input logic rw);
    return {TID, 1'b0, cs, rw};
  endfunction
  task automatic wb(input logic [7:0] b, input logic nak);
    q.push_back({7'h00, nak});
    m.wr_byte(b);
  endtask
  task automatic rb(input logic [7:0] e, input logic ack);
    q.push_back(e);
    m.rd_byte(ack);
  endtask
  task automatic addr(input logic [15:0] a);
    m.start();
    wb(sel(1'b0), 1'b0);
    wb(a[15:8], 1'b0);
    wb(a[7:0], 1'b0);
  endtask
  task automatic rd_at(input logic [15:0] a, input int n);
    addr(a);
    m.start();
    wb(sel(1'b1), 1'b0);
    for (int i = 0; i < n; i++) rb(d[1 + i], i < n - 1);
    m.stop();
  endtask
  // ====
  // Sequence
  initial begin
    arst_n = 1'b0;
    wi = 1'b0;
    void'($urandom(65175));
    cs = 2'($urandom);
    cs_lo = cs[0];
    cs_hi = cs[1];
    foreach (d[i]) d[i] = 8'($urandom);
    bad = '{{TID, 1'b0, ~cs, 1'b0}, {TID, 1'b1, cs, 1'b1}, {~TID, 1'b0, cs, 1'b0}};
    repeat (16) @(posedge sys_clk);
    #1 arst_n = 1'b1;
    repeat (4) @(posedge sys_clk);
    for (int i = 0; i < 3; i++) begin
      m.start();
      wb(bad[i], 1'b1);
      m.stop();
    end
    addr({1'b1, 9'h1A5, 6'h3F});
    foreach (d[i]) wb(d[i], 1'b0);
    m.stop();
    m.start();
    wb(sel(1'b0), 1'b1);
    m.stop();
    for (int i = 0; i < 300 && busy !== 1'b0; i++) @(posedge sys_clk);
    rd_at({1'b0, 9'h1A5, 6'h00}, 4);
    m.start();
    wb(sel(1'b1), 1'b0);
    rb(d[5], 1'b0);
    m.stop();
    wi = 1'b1;
    addr({1'b0, 9'h1A5, 6'h00});
    wb(~d[1], 1'b1);
    m.stop();
    repeat (8) @(posedge sys_clk);
    chk("busy", 8'h00, {7'h00, busy});
    rd_at({1'b0, 9'h1A5, 6'h00}, 1);
    chk("queue", 8'h00, 8'(q.size()));
    tally_and_finish();
  end
endmodule // i2cee_slave_bench
`default_nettype wire
